// ===== alu_if.sv
// operand and result bundle between the execution core and its alu
`timescale 1ns/100ps
interface alu_if;
  exec_pkg::alu_op_t op;
  logic [7:0]        a;
  logic [7:0]        b;
  logic [2:0]        bit_sel;
  logic [7:0]        result;
  logic              carry;
  logic              digit_carry;
  logic              zero;

  modport core
  (
    output op,
    output a,
    output b,
    output bit_sel,
    input  result,
    input  carry,
    input  digit_carry,
    input  zero
  );

  modport alu
  (
    input  op,
    input  a,
    input  b,
    input  bit_sel,
    output result,
    output carry,
    output digit_carry,
    output zero
  );
endinterface

// ===== alu_unit.sv
// byte alu: add, and, bit clear, bit set and pass with flag outputs
`timescale 1ns/100ps
module alu_unit
(
  alu_if.alu bus
);

  wire [4:0] low_sum;
  wire [8:0] full_sum;
  wire [7:0] bit_mask;

  // ----------------------------------------------------------------
  // adders for carry out of bit 7 and of bit 3
  // ----------------------------------------------------------------
  assign low_sum  = {1'b0, bus.a[exec_pkg::NIBBLE_W-1:0]} + {1'b0, bus.b[exec_pkg::NIBBLE_W-1:0]};
  assign full_sum = {1'b0, bus.a} + {1'b0, bus.b};
  assign bit_mask = exec_pkg::BIT_ONE << bus.bit_sel;

  always_comb
  begin
    unique case (bus.op)
      exec_pkg::ALU_ADD:  bus.result = full_sum[exec_pkg::DATA_W-1:0];
      exec_pkg::ALU_AND:  bus.result = bus.a & bus.b;
      exec_pkg::ALU_BCLR: bus.result = bus.a & ~bit_mask; // RULE13
      exec_pkg::ALU_BSET: bus.result = bus.a | bit_mask;  // RULE14
      exec_pkg::ALU_PASS: bus.result = bus.a;
      default:            bus.result = bus.a;
    endcase
  end

  assign bus.carry       = full_sum[exec_pkg::DATA_W];   // RULE19
  assign bus.digit_carry = low_sum[exec_pkg::NIBBLE_W];  // RULE19
  assign bus.zero        = (bus.result == exec_pkg::BYTE_ZERO); // RULE19

endmodule

// ===== byte_bit_instruction_exec.sv
// execution unit for the add, and, bit and bit-test-skip instructions
//
// How it works
// RULE1: flag updates override written status bits
// RULE2: reading pc low leaves holding latch alone
// RULE3: pc low write loads high byte from latch
// RULE4: bit ops read, modify, write whole byte
// RULE5: hardware status bits change only in Q1
// RULE6: four phases per cycle, one clock each
// RULE7: decode, read, process, write phases
// RULE8: add literal to accumulator, update three flags
// RULE9: add accumulator to file, update three flags
// RULE10: destination bit picks accumulator or file
// RULE11: and literal into accumulator, zero flag
// RULE12: and accumulator with file, zero flag
// RULE13: bit clear forces selected bit low
// RULE14: bit set forces selected bit high
// RULE15: skip next when tested bit is zero
// RULE16: skip next when tested bit is one
// RULE17: skip discards prefetch, runs a nop cycle
// RULE18: pc change costs two cycles, nop second
// RULE19: carry bit 7, digit carry bit 3, zero
// RULE20: seven-bit file field is the address
`timescale 1ns/100ps
module byte_bit_instruction_exec
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  output      logic [12:0] prog_addr_o,
  input  wire logic [13:0] prog_data_i,
  output      logic [6:0]  file_addr_o,
  input  wire logic [7:0]  file_rdata_i,
  output      logic [7:0]  file_wdata_o,
  output      logic        file_we_o,
  input  wire logic [7:0]  hw_status_set_i,
  input  wire logic [7:0]  hw_status_clr_i,
  output      logic [7:0]  accum_o,
  output      logic [7:0]  status_o,
  output      logic [7:0]  pc_latch_o,
  output      logic [12:0] pc_o,
  output      logic [1:0]  phase_o,
  output      logic        forced_nop_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_pkg::phase_t phase;
  logic [13:0] insn_ff;
  logic [12:0] cur_pc_ff;
  logic [12:0] pc_ff;
  logic        nop_ff;
  logic [7:0]  accum_ff;
  logic [7:0]  status_ff;
  logic [7:0]  pc_latch_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  result_ff;
  logic        carry_ff;
  logic        digit_carry_ff;
  logic        zero_ff;
  logic        skip_ff;
  logic [7:0]  pend_set_ff;
  logic [7:0]  pend_clr_ff;

  alu_if alu_bus ();

  phase_seq u_phase_seq
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .phase_o   (phase)
  );

  alu_unit u_alu_unit
  (
    .bus (alu_bus)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [5:0] opc6 = insn_ff[exec_pkg::OPC_MSB:exec_pkg::OPC6_LSB];
  wire [4:0] opc5 = insn_ff[exec_pkg::OPC_MSB:exec_pkg::OPC5_LSB];
  wire [3:0] opc4 = insn_ff[exec_pkg::OPC_MSB:exec_pkg::OPC4_LSB];
  wire [6:0] f_addr  = insn_ff[exec_pkg::FILE_MSB:0];                         // RULE20
  wire [2:0] bit_sel = insn_ff[exec_pkg::BSEL_MSB:exec_pkg::BSEL_LSB];
  wire [7:0] literal = insn_ff[exec_pkg::LIT_MSB:0];
  wire       dest_file_bit = insn_ff[exec_pkg::DEST_POS];

  wire is_add_lit   = (opc5 == exec_pkg::OPC5_ADD_LITERAL);
  wire is_and_lit   = (opc6 == exec_pkg::OPC6_AND_LITERAL);
  wire is_add_file  = (opc6 == exec_pkg::OPC6_ADD_ACCUM_TO_FILE);
  wire is_and_file  = (opc6 == exec_pkg::OPC6_AND_ACCUM_WITH_FILE);
  wire is_bit_clear = (opc4 == exec_pkg::OPC4_BIT_CLEAR);
  wire is_bit_set   = (opc4 == exec_pkg::OPC4_BIT_SET);
  wire is_skip_zero = (opc4 == exec_pkg::OPC4_TEST_SKIP_IF_ZERO);
  wire is_skip_one  = (opc4 == exec_pkg::OPC4_TEST_SKIP_IF_ONE);

  wire is_literal   = is_add_lit | is_and_lit;
  wire is_byte      = is_add_file | is_and_file;
  wire is_bit_rmw   = is_bit_clear | is_bit_set;
  wire is_bit_test  = is_skip_zero | is_skip_one;
  wire is_known     = is_literal | is_byte | is_bit_rmw | is_bit_test;

  // a forced nop or an opcode outside this unit does nothing
  wire active       = !nop_ff && is_known;                                  // RULE7
  wire reads_file   = active && (is_byte || is_bit_rmw || is_bit_test);
  wire writes_file  = active && ((is_byte && dest_file_bit) || is_bit_rmw); // RULE10 RULE4
  wire writes_accum = active && (is_literal || (is_byte && !dest_file_bit)); // RULE10
  wire upd_carries  = active && (is_add_lit || is_add_file);                // RULE8 RULE9
  wire upd_zero     = active && (is_add_lit || is_add_file || is_and_lit || is_and_file); // RULE11 RULE12

  wire sel_pc_low   = (f_addr == exec_pkg::ADDR_PC_LOW);
  wire sel_status   = (f_addr == exec_pkg::ADDR_STATUS);
  wire sel_latch    = (f_addr == exec_pkg::ADDR_PC_LATCH);
  wire sel_internal = sel_pc_low | sel_status | sel_latch;

  // ----------------------------------------------------------------
  // operand source and alu hookup
  // ----------------------------------------------------------------
  wire [7:0] file_value = sel_pc_low ? cur_pc_ff[exec_pkg::DATA_W-1:0] :      // RULE2
                          sel_status ? status_ff :
                          sel_latch  ? pc_latch_ff :
                                       file_rdata_i;
  wire [7:0] operand    = is_literal ? literal : file_value;
  wire       tested_bit = opnd_ff[bit_sel];

  assign alu_bus.op      = (is_add_lit || is_add_file) ? exec_pkg::ALU_ADD  :
                           (is_and_lit || is_and_file) ? exec_pkg::ALU_AND  :
                           is_bit_clear                ? exec_pkg::ALU_BCLR :
                           is_bit_set                  ? exec_pkg::ALU_BSET :
                                                         exec_pkg::ALU_PASS;
  assign alu_bus.a       = is_bit_rmw ? opnd_ff : accum_ff;                  // RULE4
  assign alu_bus.b       = opnd_ff;
  assign alu_bus.bit_sel = bit_sel;

  wire take_skip = active && ((is_skip_zero && !tested_bit) || (is_skip_one && tested_bit)); // RULE15 RULE16

  // ----------------------------------------------------------------
  // phase strobes and write-back terms
  // ----------------------------------------------------------------
  wire in_q1 = clk_en_i && (phase == exec_pkg::PH_Q1);
  wire in_q2 = clk_en_i && (phase == exec_pkg::PH_Q2);
  wire in_q3 = clk_en_i && (phase == exec_pkg::PH_Q3);
  wire in_q4 = clk_en_i && (phase == exec_pkg::PH_Q4);

  wire pc_low_write = writes_file && sel_pc_low;                              // RULE3
  wire status_write = writes_file && sel_status;
  wire latch_write  = writes_file && sel_latch;

  wire [12:0] jump_pc = {pc_latch_ff[exec_pkg::LATCH_MSB:0], result_ff};     // RULE3
  wire [12:0] nxt_pc  = pc_low_write ? jump_pc : pc_ff + exec_pkg::PC_STEP;

  // flags computed by the instruction win over the byte it wrote
  wire [7:0] status_base = status_write ? result_ff : status_ff;
  logic [7:0] nxt_status_q4;
  always_comb
  begin
    nxt_status_q4 = status_base;
    if (upd_carries)
    begin
      nxt_status_q4[exec_pkg::C_BIT]  = carry_ff;                            // RULE1
      nxt_status_q4[exec_pkg::DIGIT_BIT] = digit_carry_ff;                   // RULE1
    end
    if (upd_zero)
      nxt_status_q4[exec_pkg::Z_BIT] = zero_ff;                              // RULE1
  end

  // hardware events on clocks with clk_en_i high pile up until Q1, including one arriving in Q1 itself
  wire [7:0] all_set = pend_set_ff | hw_status_set_i;
  wire [7:0] all_clr = pend_clr_ff | hw_status_clr_i;
  wire [7:0] nxt_status_q1 = (status_ff & ~all_clr) | all_set;               // RULE5

  // ----------------------------------------------------------------
  // Q1: hardware status update
  // Q4: result write, fetch and pc advance
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      status_ff <= exec_pkg::BYTE_ZERO;
    else if (in_q1)
      status_ff <= nxt_status_q1;                                            // RULE5
    else if (in_q4)
      status_ff <= nxt_status_q4;                                            // RULE7
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pend_set_ff <= exec_pkg::BYTE_ZERO;
      pend_clr_ff <= exec_pkg::BYTE_ZERO;
    end
    else if (clk_en_i)
    begin
      pend_set_ff <= in_q1 ? exec_pkg::BYTE_ZERO : all_set;                  // RULE5
      pend_clr_ff <= in_q1 ? exec_pkg::BYTE_ZERO : all_clr;
    end
  end

  // ----------------------------------------------------------------
  // Q2 operand read, Q3 process
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      opnd_ff <= exec_pkg::BYTE_ZERO;
    else if (in_q2)
      opnd_ff <= operand;                                                    // RULE7
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      result_ff      <= exec_pkg::BYTE_ZERO;
      carry_ff       <= 1'b0;
      digit_carry_ff <= 1'b0;
      zero_ff        <= 1'b0;
      skip_ff        <= 1'b0;
    end
    else if (in_q3)
    begin
      result_ff      <= alu_bus.result;                                     // RULE7
      carry_ff       <= alu_bus.carry;
      digit_carry_ff <= alu_bus.digit_carry;
      zero_ff        <= alu_bus.zero;
      skip_ff        <= take_skip;                                           // RULE15 RULE16
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      accum_ff <= exec_pkg::BYTE_ZERO;
    else if (in_q4 && writes_accum)
      accum_ff <= result_ff;                                                 // RULE8 RULE10 RULE11
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      pc_latch_ff <= exec_pkg::BYTE_ZERO;
    else if (in_q4 && latch_write)
      pc_latch_ff <= result_ff;
  end

  // the word fetched here is dropped when the next cycle is forced to a nop
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      insn_ff   <= exec_pkg::INSN_RESET;
      cur_pc_ff <= exec_pkg::PC_RESET;
      pc_ff     <= exec_pkg::PC_RESET;
      nop_ff    <= 1'b1;
    end
    else if (in_q4)
    begin
      insn_ff   <= prog_data_i;
      cur_pc_ff <= pc_ff;
      pc_ff     <= nxt_pc;                                                   // RULE3
      nop_ff    <= pc_low_write || skip_ff;                                  // RULE17 RULE18
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      file_wdata_o <= exec_pkg::BYTE_ZERO;
    else if (in_q3)
      file_wdata_o <= alu_bus.result;                                        // RULE4
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prog_addr_o  = pc_ff;
  assign file_addr_o  = f_addr;                                              // RULE20
  assign file_we_o    = in_q4 && writes_file && !sel_internal;               // RULE4
  assign accum_o      = accum_ff;
  assign status_o     = status_ff;
  assign pc_latch_o   = pc_latch_ff;
  assign pc_o         = cur_pc_ff;
  assign phase_o      = phase;
  assign forced_nop_o = nop_ff;

  wire unused_read = reads_file;

endmodule

// ===== byte_bit_instruction_exec_assertions.sv
// port-level checks of the byte and bit execution unit
`timescale 1ns/100ps
module byte_bit_instruction_exec_assertions
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        clk_en_i,
  input wire logic [12:0] prog_addr_o,
  input wire logic [6:0]  file_addr_o,
  input wire logic        file_we_o,
  input wire logic [7:0]  accum_o,
  input wire logic [7:0]  status_o,
  input wire logic [1:0]  phase_o,
  input wire logic        forced_nop_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------
  // cycle structure
  // ----------------------------------------
  a_phase_steps : assert property (reset_n_i |=>
    phase_o == 2'($past(phase_o) + {1'b0, $past(clk_en_i)}))
    else $error("phase sequence broken");
  a_fetch_held : assert property (phase_o != 2'd3 |=> $stable(prog_addr_o))
    else $error("fetch address moved mid cycle");
  a_write_in_q4 : assert property (file_we_o |-> phase_o == 2'd3 && clk_en_i)
    else $error("file write outside the write phase");
  a_accum_in_q4 : assert property ($changed(accum_o) && $past(reset_n_i) |-> $past(phase_o) == 2'd3)
    else $error("accumulator changed outside the write phase");
  a_status_q1_q4 : assert property ($changed(status_o) && $past(reset_n_i) |->
    $past(phase_o) inside {2'd0, 2'd3})
    else $error("status changed in a read or process phase");
  a_internal_kept : assert property (file_we_o |-> !(file_addr_o inside {7'h02, 7'h03, 7'h0a}))
    else $error("internal register written on the file bus");
  a_nop_no_write : assert property (forced_nop_o |-> !file_we_o)
    else $error("file write during a forced nop");
  a_nop_from_q1 : assert property ($rose(forced_nop_o) |-> phase_o == 2'd0 && $past(phase_o) == 2'd3)
    else $error("forced nop did not start a cycle");
  a_addr_held : assert property (phase_o != 2'd0 |-> $stable(file_addr_o))
    else $error("file address moved mid cycle");

  c_write : cover property (file_we_o);
  c_nop : cover property ($rose(forced_nop_o));
  c_status : cover property (phase_o == 2'd1 && $changed(status_o));
endmodule

// ===== byte_bit_instruction_exec_tb.sv
// self-checking bench for the byte and bit execution unit
`timescale 1ns/100ps
module byte_bit_instruction_exec_tb;
  localparam logic [5:0] ADDL = {exec_pkg::OPC5_ADD_LITERAL, 1'b0};
  localparam logic [5:0] ANDL = exec_pkg::OPC6_AND_LITERAL;
  localparam logic [5:0] ADDF = exec_pkg::OPC6_ADD_ACCUM_TO_FILE;
  localparam logic [5:0] ANDF = exec_pkg::OPC6_AND_ACCUM_WITH_FILE;

  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic [7:0]  hw_set = 8'h00;
  logic [7:0]  hw_clr = 8'h00;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  accum;
  logic [7:0]  status;
  logic [7:0]  pc_latch;
  logic [12:0] pc;
  logic [1:0]  phase;
  logic        nop;
  int          num_errors = 0;
  int          compares = 0;
  int          nops = 0;
  int          clocks = 0;
  logic [13:0] p[$];

  byte_bit_instruction_exec i_dut
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .prog_addr_o(prog_addr),
    .prog_data_i(prog_data), .file_addr_o(file_addr), .file_rdata_i(file_rdata), .file_wdata_o(file_wdata),
    .file_we_o(file_we), .hw_status_set_i(hw_set), .hw_status_clr_i(hw_clr), .accum_o(accum),
    .status_o(status), .pc_latch_o(pc_latch), .pc_o(pc), .phase_o(phase), .forced_nop_o(nop)
  );

  prog_file_model i_mem
  (
    .clk_i(clk_i), .prog_addr_i(prog_addr), .prog_data_o(prog_data), .file_addr_i(file_addr),
    .file_rdata_o(file_rdata), .file_wdata_i(file_wdata), .file_we_i(file_we)
  );

  always #10 clk_i = ~clk_i;

  // ----------------------------------------
  // nop counting and hang guard
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    clocks++;
    if (reset_n_i && clk_en_i && phase === 2'd0 && nop === 1'b1)
      nops++;
    if (clocks == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [13:0] bop(input logic [3:0] o, input int b, input logic [6:0] f);
    return {o, b[2:0], f};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic prep();
    reset_n_i = 1'b0;
    for (int a = 0; a < 8192; a++)
      i_mem.prog_mem[a] = (a < p.size()) ? p[a] : 14'h0000;
    nops = 0;
  endtask

  // release reset, optionally stall, run until the last word has written back
  task automatic run(input logic [12:0] last, input int stall = 0);
    int n;
    n = 0;
    tick(4);
    reset_n_i = 1'b1;
    tick(2);
    clk_en_i = (stall == 0);
    tick(stall);
    clk_en_i = 1'b1;
    while (!(pc === last && phase === 2'd3 && nop === 1'b0) && n < 400)
    begin
      tick();
      n++;
    end
    check(8'(n < 400), 8'h01);
    tick();
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic arith_dest();
    p = '{{ADDL, 8'h8f}, {ADDL, 8'h71}, {ADDL, 8'h17}, {ADDF, 8'ha0}, {ANDF, 8'h7f}, {ANDL, 8'hfe}};
    prep();
    i_mem.file_mem[32] = 8'hf9;
    i_mem.file_mem[127] = 8'hc9;
    run(13'h0005, 3);
    check(accum, 8'h00);
    check(status, 8'h07);
    check(i_mem.file_mem[32], 8'h10);
    check(i_mem.file_mem[127], 8'hc9);
  endtask

  task automatic add_flags();
    logic [7:0] t [5][4] = '{'{8'h88, 8'h88, 8'h10, 8'h03}, '{8'hff, 8'h01, 8'h00, 8'h07},
      '{8'h0f, 8'h01, 8'h10, 8'h02}, '{8'h40, 8'h40, 8'h80, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h04}};
    for (int i = 0; i < 5; i++)
    begin
      p = '{{exec_pkg::OPC5_ADD_LITERAL, i[0], t[i][0]}, {exec_pkg::OPC5_ADD_LITERAL, i[1], t[i][1]}};
      prep();
      run(13'h0001);
      check(accum, t[i][2]);
      check(status, t[i][3]);
    end
  endtask

  task automatic status_dest();
    p = '{bop(exec_pkg::OPC4_BIT_SET, 6, 7'h03), {ADDL, 8'h00}, {ANDF, 8'h83}};
    prep();
    run(13'h0002);
    check(status, 8'h04);
  endtask

  task automatic bit_ops();
    p = '{{ADDL, 8'h00}, bop(exec_pkg::OPC4_BIT_CLEAR, 7, 7'h45), bop(exec_pkg::OPC4_BIT_SET, 3, 7'h45)};
    for (int b = 0; b < 8; b++)
    begin
      p.push_back(bop(exec_pkg::OPC4_BIT_SET, b, 7'h30));
      p.push_back(bop(exec_pkg::OPC4_BIT_CLEAR, b, 7'h31));
    end
    prep();
    i_mem.file_mem[69] = 8'hc7;
    i_mem.file_mem[48] = 8'h00;
    i_mem.file_mem[49] = 8'hff;
    run(13'h0012);
    check(i_mem.file_mem[69], 8'h4f);
    check(i_mem.file_mem[48], 8'hff);
    check(i_mem.file_mem[49], 8'h00);
    check(status, 8'h04);
  endtask

  task automatic skips();
    p = '{bop(exec_pkg::OPC4_TEST_SKIP_IF_ZERO, 4, 7'h50), {ADDL, 8'h01},
      bop(exec_pkg::OPC4_TEST_SKIP_IF_ONE, 4, 7'h50), {ADDL, 8'h02},
      bop(exec_pkg::OPC4_TEST_SKIP_IF_ZERO, 3, 7'h50), {ADDL, 8'h04},
      bop(exec_pkg::OPC4_TEST_SKIP_IF_ONE, 0, 7'h50), {ADDL, 8'h08}};
    prep();
    i_mem.file_mem[80] = 8'h10;
    run(13'h0007);
    check(accum, 8'h09);
    check(8'(nops), 8'h03);
  endtask

  task automatic pc_low();
    p = '{{ADDL, 8'h03}, {ADDF, 8'h8a}, {ADDF, 8'h02}, {ADDF, 8'h82}, {ADDL, 8'h40}};
    prep();
    i_mem.prog_mem[776] = {ADDL, 8'h10};
    run(13'h0308);
    check(accum, 8'h15);
    check(pc_latch, 8'h03);
    check(8'(nops), 8'h02);
  endtask

  task automatic hw_status();
    int n;
    p = '{bop(exec_pkg::OPC4_BIT_SET, 6, 7'h03)};
    prep();
    tick(4);
    reset_n_i = 1'b1;
    n = 0;
    while (!(pc === 13'h0000 && phase === 2'd1 && nop === 1'b0) && n < 40)
    begin
      tick();
      n++;
    end
    hw_set = 8'h20;
    tick();
    hw_set = 8'h00;
    check(status, 8'h00);
    tick(2);
    check(status, 8'h40);
    tick();
    check(status, 8'h60);
    hw_set = 8'h40;
    hw_clr = 8'h60;
    tick();
    hw_set = 8'h00;
    hw_clr = 8'h00;
    tick(4);
    check(status, 8'h40);
  endtask

  initial
  begin
    arith_dest();
    add_flags();
    status_dest();
    bit_ops();
    skips();
    pc_low();
    hw_status();
    stop_test();
  end
endmodule

bind byte_bit_instruction_exec byte_bit_instruction_exec_assertions i_chk
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .prog_addr_o(prog_addr_o),
  .file_addr_o(file_addr_o), .file_we_o(file_we_o), .accum_o(accum_o), .status_o(status_o),
  .phase_o(phase_o), .forced_nop_o(forced_nop_o)
);

// ===== exec_pkg.sv
// constants, field layouts and enumerations of the byte and bit execution unit
package exec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W     = 13;
  localparam int INSN_W   = 14;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 7;
  localparam int BSEL_W   = 3;
  localparam int NIBBLE_W = 4;

  // ----------------------------------------------------------------
  // instruction field positions
  // ----------------------------------------------------------------
  localparam int OPC_MSB    = 13;
  localparam int OPC6_LSB   = 8;
  localparam int OPC5_LSB   = 9;
  localparam int OPC4_LSB   = 10;
  localparam int DEST_POS   = 7;
  localparam int FILE_MSB   = 6;
  localparam int BSEL_MSB   = 9;
  localparam int BSEL_LSB   = 7;
  localparam int LIT_MSB    = 7;
  localparam int LATCH_MSB  = 4;

  // ----------------------------------------------------------------
  // opcode codes
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC6_ADD_ACCUM_TO_FILE  = 6'h07;
  localparam logic [5:0] OPC6_AND_ACCUM_WITH_FILE = 6'h05;
  localparam logic [5:0] OPC6_AND_LITERAL        = 6'h39;
  localparam logic [4:0] OPC5_ADD_LITERAL        = 5'h1F;
  localparam logic [3:0] OPC4_BIT_CLEAR          = 4'h4;
  localparam logic [3:0] OPC4_BIT_SET            = 4'h5;
  localparam logic [3:0] OPC4_TEST_SKIP_IF_ZERO  = 4'h6;
  localparam logic [3:0] OPC4_TEST_SKIP_IF_ONE   = 4'h7;

  // ----------------------------------------------------------------
  // internal file addresses and status bits
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PC_LOW   = 7'h02;
  localparam logic [6:0] ADDR_STATUS   = 7'h03;
  localparam logic [6:0] ADDR_PC_LATCH = 7'h0A;
  localparam int C_BIT     = 0;
  localparam int DIGIT_BIT = 1;
  localparam int Z_BIT     = 2;

  // ----------------------------------------------------------------
  // reset values, pc step and bit mask seed
  // ----------------------------------------------------------------
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [12:0] PC_STEP      = 13'h0001;
  localparam logic [13:0] INSN_RESET   = 14'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BIT_ONE      = 8'h01;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [2:0]
  {
    ALU_PASS = 3'b000,
    ALU_ADD  = 3'b001,
    ALU_AND  = 3'b010,
    ALU_BCLR = 3'b011,
    ALU_BSET = 3'b100
  } alu_op_t;

endpackage

// ===== phase_seq.sv
// four-phase instruction cycle sequencer
`timescale 1ns/100ps
module phase_seq
(
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            clk_en_i,
  output exec_pkg::phase_t     phase_o
);

  exec_pkg::phase_t phase_ff;
  exec_pkg::phase_t nxt_phase;

  // ----------------------------------------------------------------
  // one phase per clock with clk_en_i high, four per cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (phase_ff)
      exec_pkg::PH_Q1: nxt_phase = exec_pkg::PH_Q2; // RULE6
      exec_pkg::PH_Q2: nxt_phase = exec_pkg::PH_Q3;
      exec_pkg::PH_Q3: nxt_phase = exec_pkg::PH_Q4;
      exec_pkg::PH_Q4: nxt_phase = exec_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      phase_ff <= exec_pkg::PH_Q1;
    else if (clk_en_i)
      phase_ff <= nxt_phase;
  end

  assign phase_o = phase_ff;

endmodule

// ===== prog_file_model.sv
// program memory and data file on the far side of the execution unit
`timescale 1ns/100ps
module prog_file_model
(
  input  wire logic        clk_i,
  input  wire logic [12:0] prog_addr_i,
  output      logic [13:0] prog_data_o,
  input  wire logic [6:0]  file_addr_i,
  output      logic [7:0]  file_rdata_o,
  input  wire logic [7:0]  file_wdata_i,
  input  wire logic        file_we_i
);
  logic [13:0] prog_mem [8192];
  logic [7:0]  file_mem [128];

  assign prog_data_o  = prog_mem[prog_addr_i];
  assign file_rdata_o = file_mem[file_addr_i];

  always @(posedge clk_i)
  begin
    if (file_we_i)
      file_mem[file_addr_i] <= file_wdata_i;
  end
endmodule
